// >>> rtl/bsio_defines.svh
// Offsets, field positions, external codes and timing counts of the bit I/O unit
`ifndef BSIO_DEFINES_SVH
`define BSIO_DEFINES_SVH
// Register offsets on the plain register port
`define BSIO_OFS_CMD 8'h00
`define BSIO_OFS_BASE 8'h04
`define BSIO_OFS_DATA 8'h08
`define BSIO_OFS_ST 8'h0c
`define BSIO_OFS_WP 8'h10
`define BSIO_OFS_PC 8'h14
`define BSIO_OFS_STAT 8'h18
// Command word fields
`define BSIO_CMD_DISP 7:0
`define BSIO_CMD_VAL 8
`define BSIO_CMD_OP 11:9
`define BSIO_CMD_CNT 15:12
// Status word: processor bit 2 is bit 13 here, the mask is processor bits 12 to 15
`define BSIO_ST_EQ 13
`define BSIO_ST_MASK 3:0
// External instruction codes on A0..A2
`define BSIO_EXT_LOADER 3'h7
`define BSIO_EXT_CLK_OFF 3'h6
`define BSIO_EXT_CLK_ON 3'h5
`define BSIO_EXT_RESET 3'h3
`define BSIO_EXT_IDLE 3'h2
// Bootstrap trap vector and context slots (workspace registers 13, 14, 15)
`define BSIO_TRAP_VEC_WP 16'hfffc
`define BSIO_TRAP_VEC_PC 16'hfffe
`define BSIO_CTX_WP_OFS 16'h001a
`define BSIO_CTX_PC_OFS 16'h001c
`define BSIO_CTX_ST_OFS 16'h001e
// Every bit, code or memory cycle takes four clock phases
`define BSIO_PH_STROBE 2'h1
`define BSIO_PH_LAST 2'h3
`define BSIO_FIELD_MAX 5'h10
`define BSIO_BYTE_MAX 5'h08
`endif

// >>> rtl/bsio_pkg.sv
// Types of the bit I/O unit: states, operations and the state record
package bsio_pkg;
   typedef enum logic [3:0] {
      S_READY = 4'h0,
      S_BIT = 4'h1,
      S_EXT = 4'h2,
      S_IDLE = 4'h3,
      S_T_VWP = 4'h4,
      S_T_VPC = 4'h5,
      S_T_W13 = 4'h6,
      S_T_W14 = 4'h7,
      S_T_W15 = 4'h8
   } bsio_state_t;

   typedef enum logic [2:0] {
      OP_SET_BIT = 3'h1,
      OP_TEST_BIT = 3'h2,
      OP_LOAD_FIELD = 3'h3,
      OP_STORE_FIELD = 3'h4,
      OP_EXT = 3'h5
   } bsio_op_t;

   typedef struct packed {
      bsio_state_t state;
      bsio_op_t op;
      logic [1:0] phase;
      logic [4:0] nbits;
      logic [4:0] bits_left;
      logic [11:0] bit_addr;
      logic [15:0] shift;
      logic val;
      logic byte_sel;
      logic [2:0] ext_code;
      logic [15:0] base;
      logic [15:0] data;
      logic [15:0] st;
      logic [15:0] wp;
      logic [15:0] pc;
      logic [15:0] new_wp;
      logic [15:0] new_pc;
      logic trap_pend;
      logic sin_s1;
      logic sin_s2;
      logic ld_s1;
      logic ld_s2;
      logic ld_prev;
      logic int_s1;
      logic int_s2;
      logic hold_s1;
      logic hold_s2;
      logic [15:0] din_s1;
      logic [15:0] din_s2;
      logic [14:0] addr_bus;
      logic addr_oe;
      logic serial_out;
      logic output_strobe;
      logic mce;
      logic mem_we;
      logic [15:0] data_o;
      logic data_oe;
      logic hold_ack;
      logic [15:0] rdata;
   } bsio_regs_t;
endpackage : bsio_pkg

// >>> rtl/bsio_core.sv
// Bit-addressed serial I/O unit with external codes, idle and bootstrap trap
// Function
// - 4096 input and 4096 output bits, 12-bit address on A3..A14.
// - Single bits and fields of 1 to 16 bits.
// - Set/clear drive instruction bit 7 on serial out with one strobe.
// - Test bit samples serial in into status bit 2.
// - Single-bit address is base register plus signed 8-bit displacement.
// - Load field of up to 8 bits uses the addressed byte, else word.
// - Field bits take rising addresses, memory LSB at lowest address.
// - Store field writes right-justified, zero-filled byte or word.
// - First bit read lands in the destination LSB.
// - Five external codes go out on A0..A2 with one strobe.
// - Idle stops execution until interrupt, reset or bootstrap trap.
// - While idle the idle code and strobe repeat.
// - Bootstrap trap after current operation, vector FFFC, mask cleared.
// - Memory addresses with cycle enable, I/O addresses without it.
// - Address bus floats while hold is acknowledged.
// - Trap stores old WP, PC, ST in new registers 13, 14, 15.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "bsio_defines.svh"
module bsio_core (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [15:0] reg_rdata,
   // Bit I/O pins
   input wire logic serial_in_line,
   output logic serial_out_line,
   output logic output_strobe,
   // Address bus, A0 is bit 14 and A14 is bit 0
   output logic [14:0] addr_bus,
   output logic addr_oe,
   // Memory bus
   output logic memory_cycle_enable,
   output logic mem_we,
   input wire logic [15:0] data_in,
   output logic [15:0] data_out,
   output logic data_oe,
   // Hold, interrupt and bootstrap
   input wire logic hold_req,
   output logic hold_acknowledge,
   input wire logic intr_req,
   input wire logic bootstrap_n
);
   bsio_pkg::bsio_regs_t r_reg;
   bsio_pkg::bsio_regs_t r_next;
   logic cmd_go;
   logic [11:0] single_addr;
   logic [15:0] fld;
   logic [15:0] mem_a;
   logic [15:0] wdat;
   logic out_op;

   // -------------------------------------------------------------
   // Command decode
   // -------------------------------------------------------------
   // no start while idle
   assign cmd_go = reg_we && reg_addr == `BSIO_OFS_CMD && r_reg.state == bsio_pkg::S_READY
      && !r_reg.hold_ack && !r_reg.trap_pend
      && reg_wdata[`BSIO_CMD_OP] >= 3'h1 && reg_wdata[`BSIO_CMD_OP] <= 3'h5;
   assign single_addr = r_reg.base[12:1] + {{4{reg_wdata[7]}}, reg_wdata[`BSIO_CMD_DISP]};

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      r_next = r_reg;
      fld = 16'h0000;
      mem_a = 16'h0000;
      wdat = 16'h0000;
      out_op = 1'b0;
      r_next.sin_s1 = serial_in_line;
      r_next.sin_s2 = r_reg.sin_s1;
      r_next.ld_s1 = bootstrap_n;
      r_next.ld_s2 = r_reg.ld_s1;
      r_next.ld_prev = r_reg.ld_s2;
      r_next.int_s1 = intr_req;
      r_next.int_s2 = r_reg.int_s1;
      r_next.hold_s1 = hold_req;
      r_next.hold_s2 = r_reg.hold_s1;
      r_next.din_s1 = data_in;
      r_next.din_s2 = r_reg.din_s1;
      if (reg_we) begin
         unique case (reg_addr)
            `BSIO_OFS_BASE: r_next.base = reg_wdata;
            `BSIO_OFS_DATA: r_next.data = reg_wdata;
            `BSIO_OFS_ST: r_next.st = reg_wdata;
            `BSIO_OFS_WP: r_next.wp = reg_wdata;
            `BSIO_OFS_PC: r_next.pc = reg_wdata;
            default: ;
         endcase
      end
      if (cmd_go) begin
         r_next.op = bsio_pkg::bsio_op_t'(reg_wdata[`BSIO_CMD_OP]);
         r_next.phase = 2'h0;
         r_next.val = reg_wdata[`BSIO_CMD_VAL];
         r_next.byte_sel = reg_wdata[0];
         r_next.ext_code = reg_wdata[2:0];
         r_next.state = bsio_pkg::S_BIT;
         // count 0 means a full 16-bit field
         r_next.nbits = reg_wdata[`BSIO_CMD_CNT] == 4'h0 ? `BSIO_FIELD_MAX : {1'b0, reg_wdata[`BSIO_CMD_CNT]};
         r_next.bit_addr = r_reg.base[12:1];
         r_next.shift = 16'h0000;
         unique case (reg_wdata[`BSIO_CMD_OP])
            3'h1, 3'h2: begin
               r_next.nbits = 5'h01;
               r_next.bit_addr = single_addr;
            end
            3'h3: begin
               // byte source for short fields, word source otherwise
               if (r_next.nbits <= `BSIO_BYTE_MAX) begin
                  r_next.shift = {8'h00, reg_wdata[0] ? r_reg.data[7:0] : r_reg.data[15:8]};
               end else begin
                  r_next.shift = r_reg.data;
               end
            end
            3'h5: r_next.state = bsio_pkg::S_EXT;
            default: ;
         endcase
         r_next.bits_left = r_next.nbits;
      end
      unique case (r_reg.state)
         bsio_pkg::S_READY: begin
            // trap taken at an operation boundary
            if (r_reg.trap_pend && !r_reg.hold_ack) begin
               r_next.state = bsio_pkg::S_T_VWP;
               r_next.phase = 2'h0;
               r_next.trap_pend = 1'b0;
            end
         end
         bsio_pkg::S_BIT: begin
            r_next.phase = r_reg.phase + 2'h1;
            if (r_reg.phase == `BSIO_PH_LAST) begin
               // sampled input into the equal flag
               if (r_reg.op == bsio_pkg::OP_TEST_BIT) begin
                  r_next.st[`BSIO_ST_EQ] = r_reg.sin_s2;
               end
               // first bit shifts down to the LSB
               r_next.shift = {r_reg.op == bsio_pkg::OP_STORE_FIELD && r_reg.sin_s2, r_reg.shift[15:1]};
               // next bit at the next address
               r_next.bit_addr = r_reg.bit_addr + 12'h001;
               r_next.bits_left = r_reg.bits_left - 5'h01;
               if (r_reg.bits_left == 5'h01) begin
                  r_next.state = bsio_pkg::S_READY;
                  fld = r_next.shift >> (`BSIO_FIELD_MAX - r_reg.nbits);
                  if (r_reg.op == bsio_pkg::OP_STORE_FIELD) begin
                     if (r_reg.nbits > `BSIO_BYTE_MAX) begin
                        r_next.data = fld;
                     end else if (r_reg.byte_sel) begin
                        r_next.data[7:0] = fld[7:0];
                     end else begin
                        r_next.data[15:8] = fld[7:0];
                     end
                  end
               end
            end
         end
         bsio_pkg::S_EXT, bsio_pkg::S_IDLE: begin
            r_next.phase = r_reg.phase + 2'h1;
            if (r_reg.phase == `BSIO_PH_LAST) begin
               // idle ends only on interrupt or trap
               if (r_reg.state == bsio_pkg::S_EXT && r_reg.ext_code != `BSIO_EXT_IDLE) begin
                  r_next.state = bsio_pkg::S_READY;
               end else if (r_reg.int_s2 || r_reg.trap_pend) begin
                  r_next.state = bsio_pkg::S_READY;
               end else begin
                  r_next.state = bsio_pkg::S_IDLE;
               end
            end
         end
         default: begin
            r_next.phase = r_reg.phase + 2'h1;
            if (r_reg.phase == `BSIO_PH_LAST) begin
               unique case (r_reg.state)
                  bsio_pkg::S_T_VWP: begin
                     r_next.new_wp = r_reg.din_s2;
                     r_next.state = bsio_pkg::S_T_VPC;
                  end
                  bsio_pkg::S_T_VPC: begin
                     r_next.new_pc = r_reg.din_s2;
                     r_next.state = bsio_pkg::S_T_W13;
                  end
                  bsio_pkg::S_T_W13: r_next.state = bsio_pkg::S_T_W14;
                  bsio_pkg::S_T_W14: r_next.state = bsio_pkg::S_T_W15;
                  default: begin
                     // new context and mask of zero
                     r_next.wp = r_reg.new_wp;
                     r_next.pc = r_reg.new_pc;
                     r_next.st[`BSIO_ST_MASK] = 4'h0;
                     r_next.state = bsio_pkg::S_READY;
                  end
               endcase
            end
         end
      endcase
      // A request that lands as the trap starts is kept: set wins over clear
      if (!r_reg.ld_s2 && r_reg.ld_prev) begin
         r_next.trap_pend = 1'b1;
      end

      // -------------------------------------------------------------
      // Pin outputs, all taken from the next state
      // -------------------------------------------------------------
      // old context into registers 13, 14, 15
      unique case (r_next.state)
         bsio_pkg::S_T_VWP: mem_a = `BSIO_TRAP_VEC_WP;
         bsio_pkg::S_T_VPC: mem_a = `BSIO_TRAP_VEC_PC;
         bsio_pkg::S_T_W13: begin
            mem_a = r_next.new_wp + `BSIO_CTX_WP_OFS;
            wdat = r_next.wp;
         end
         bsio_pkg::S_T_W14: begin
            mem_a = r_next.new_wp + `BSIO_CTX_PC_OFS;
            wdat = r_next.pc;
         end
         bsio_pkg::S_T_W15: begin
            mem_a = r_next.new_wp + `BSIO_CTX_ST_OFS;
            wdat = r_next.st;
         end
         default: ;
      endcase
      r_next.mce = r_next.state >= bsio_pkg::S_T_VWP;
      r_next.data_oe = r_next.state >= bsio_pkg::S_T_W13;
      r_next.data_o = wdat;
      r_next.mem_we = r_next.data_oe && r_next.phase == `BSIO_PH_STROBE;
      // memory address with cycle enable, bit address or code without
      if (r_next.mce) begin
         r_next.addr_bus = mem_a[15:1];
      end else if (r_next.state == bsio_pkg::S_BIT) begin
         r_next.addr_bus = {3'h0, r_next.bit_addr};
      end else if (r_next.state == bsio_pkg::S_EXT || r_next.state == bsio_pkg::S_IDLE) begin
         // code on A0..A2, low lines quiet
         r_next.addr_bus = {r_next.state == bsio_pkg::S_IDLE ? `BSIO_EXT_IDLE : r_next.ext_code, 12'h000};
      end else begin
         r_next.addr_bus = 15'h0000;
      end
      // set/clear value or field bit, LSB first
      r_next.serial_out = 1'b0;
      if (r_next.state == bsio_pkg::S_BIT) begin
         if (r_next.op == bsio_pkg::OP_SET_BIT) begin
            r_next.serial_out = r_next.val;
         end else if (r_next.op == bsio_pkg::OP_LOAD_FIELD) begin
            r_next.serial_out = r_next.shift[0];
         end
      end
      out_op = r_next.op == bsio_pkg::OP_SET_BIT || r_next.op == bsio_pkg::OP_LOAD_FIELD;
      // strobe in the second phase, address set one phase earlier
      r_next.output_strobe = r_next.phase == `BSIO_PH_STROBE
         && ((r_next.state == bsio_pkg::S_BIT && out_op)
         || r_next.state == bsio_pkg::S_EXT || r_next.state == bsio_pkg::S_IDLE);
      // Hold is granted only between operations, so no bit cycle is split
      r_next.hold_ack = r_reg.hold_s2 && r_next.state == bsio_pkg::S_READY;
      r_next.addr_oe = !r_next.hold_ack;
      r_next.rdata = 16'h0000;
      if (reg_re) begin
         unique case (reg_addr)
            `BSIO_OFS_BASE: r_next.rdata = r_reg.base;
            `BSIO_OFS_DATA: r_next.rdata = r_reg.data;
            `BSIO_OFS_ST: r_next.rdata = r_reg.st;
            `BSIO_OFS_WP: r_next.rdata = r_reg.wp;
            `BSIO_OFS_PC: r_next.rdata = r_reg.pc;
            `BSIO_OFS_STAT: r_next.rdata = {12'h000, r_reg.hold_ack, r_reg.trap_pend,
               r_reg.state == bsio_pkg::S_IDLE, r_reg.state != bsio_pkg::S_READY};
            default: ;
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r_reg <= '0;
         r_reg.ld_s1 <= 1'b1;
         r_reg.ld_s2 <= 1'b1;
         r_reg.ld_prev <= 1'b1;
         r_reg.addr_oe <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign reg_rdata = r_reg.rdata;
   assign serial_out_line = r_reg.serial_out;
   assign output_strobe = r_reg.output_strobe;
   assign addr_bus = r_reg.addr_bus;
   assign addr_oe = r_reg.addr_oe;
   assign memory_cycle_enable = r_reg.mce;
   assign mem_we = r_reg.mem_we;
   assign data_out = r_reg.data_o;
   assign data_oe = r_reg.data_oe;
   assign hold_acknowledge = r_reg.hold_ack;
   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence seq_trap_go; r_reg.state == bsio_pkg::S_READY && r_reg.trap_pend && !r_reg.hold_ack; endsequence
   sequence seq_vector_read; memory_cycle_enable && addr_bus == 15'h7ffe && !data_oe; endsequence
   AST_SET_VALUE: assert property (output_strobe && r_reg.state == bsio_pkg::S_BIT
      && r_reg.op == bsio_pkg::OP_SET_BIT |-> serial_out_line == r_reg.val) else $error("set/clear value wrong");
   AST_TEST_EQ: assert property (r_reg.state == bsio_pkg::S_BIT && r_reg.op == bsio_pkg::OP_TEST_BIT
      && r_reg.phase == `BSIO_PH_LAST |=> r_reg.st[`BSIO_ST_EQ] == $past(r_reg.sin_s2)) else $error("bad test bit");
   AST_SINGLE_ADDR: assert property (cmd_go && reg_wdata[`BSIO_CMD_OP] <= 3'h2
      |=> addr_bus[11:0] == $past(single_addr) && !memory_cycle_enable) else $error("single-bit address wrong");
   AST_FIELD_STEP: assert property (r_reg.state == bsio_pkg::S_BIT && r_reg.phase == `BSIO_PH_LAST
      && r_reg.bits_left != 5'h01 |=> addr_bus[11:0] == $past(addr_bus[11:0]) + 12'h001) else $error("bad step");
   AST_STROBE_STABLE: assert property ($rose(output_strobe) |-> $stable(addr_bus)
      && $stable(serial_out_line) ##1 !output_strobe && $stable(addr_bus) && $stable(serial_out_line))
      else $error("strobe while address or data moving");
   AST_EXT_CODE: assert property (output_strobe && r_reg.state == bsio_pkg::S_EXT
      |-> addr_bus[14:12] == r_reg.ext_code && addr_bus[11:0] == 12'h000 && !memory_cycle_enable)
      else $error("external code missing at strobe");
   AST_IDLE_STAYS: assert property (r_reg.state == bsio_pkg::S_IDLE && !r_reg.int_s2
      && !r_reg.trap_pend && !cmd_go |=> r_reg.state == bsio_pkg::S_IDLE) else $error("idle left without cause");
   AST_IDLE_REPEAT: assert property (r_reg.state == bsio_pkg::S_IDLE && r_reg.phase == `BSIO_PH_LAST
      && !r_reg.int_s2 && !r_reg.trap_pend |-> ##2 (output_strobe && addr_bus[14:12] == `BSIO_EXT_IDLE))
      else $error("idle code not repeated");
   AST_TRAP_VEC: assert property (seq_trap_go |=> seq_vector_read) else $error("trap vector not read");
   AST_TRAP_MASK: assert property (r_reg.state == bsio_pkg::S_T_W15 && r_reg.phase == `BSIO_PH_LAST
      |=> r_reg.st[`BSIO_ST_MASK] == 4'h0 && r_reg.wp == $past(r_reg.new_wp)) else $error("trap context wrong");
   AST_CTX_SAVE: assert property (mem_we && r_reg.state == bsio_pkg::S_T_W13
      |-> data_out == r_reg.wp && data_oe && memory_cycle_enable) else $error("old workspace pointer not saved");
   AST_MCE_ADDR: assert property (memory_cycle_enable |-> !output_strobe
      && r_reg.state >= bsio_pkg::S_T_VWP) else $error("memory cycle mixed with bit cycle");
   AST_HOLD_HIZ: assert property (hold_acknowledge |-> !addr_oe && !data_oe
      && !memory_cycle_enable && !output_strobe) else $error("bus driven during hold");
endmodule : bsio_core

// >>> test/bsio_far_model.sv
// Far-side model: decoded I/O bit latches, input selector, external code decode, memory
`timescale 1ns/100ps
module bsio_far_model (
   // Clock
   input wire logic clk,
   // Bit I/O pins
   input wire logic serial_out_line,
   input wire logic output_strobe,
   output logic serial_in_line,
   // Address and memory bus
   input wire logic [14:0] addr_bus,
   input wire logic memory_cycle_enable,
   input wire logic mem_we,
   input wire logic [15:0] data_out,
   input wire logic data_oe,
   output logic [15:0] data_in
);
   // ----------------------------------------
   // Bit space and memory
   // ----------------------------------------
   logic out_bits [4096];
   logic in_bits [4096];
   logic [15:0] mem [32768];
   logic [15:0] last_d = 16'h0000;
   logic [2:0] last_code = 3'h0;
   int strobes = 0;

   initial begin
      for (int i = 0; i < 4096; i++) begin
         out_bits[i] = 1'b0;
         in_bits[i] = 1'b0;
      end
   end

   assign serial_in_line = in_bits[addr_bus[11:0]];
   // Released bus shows the inverse of its last value, never a kind constant
   assign data_in = (memory_cycle_enable && !data_oe) ? mem[addr_bus] : ~last_d;

   always @(posedge clk) begin
      if (memory_cycle_enable && !data_oe)
         last_d <= data_in;
      if (mem_we)
         mem[addr_bus] <= data_out;
      if (output_strobe) begin
         strobes <= strobes + 1;
         if (addr_bus[14:12] == 3'h0)
            out_bits[addr_bus[11:0]] <= serial_out_line;
         else
            last_code <= addr_bus[14:12];
      end
   end
endmodule : bsio_far_model

// >>> test/testbench.sv
// Self-checking bench for the bit I/O unit driven over its register port
`timescale 1ns/100ps
`include "bsio_defines.svh"
module testbench;
   // ----------------------------------------
   // Signals and instances
   // ----------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic [15:0] reg_rdata;
   logic serial_in_line, serial_out_line, output_strobe;
   logic [14:0] addr_bus;
   logic addr_oe, memory_cycle_enable, mem_we, data_oe, hold_acknowledge;
   logic [15:0] data_in, data_out;
   logic hold_req = 1'b0;
   logic intr_req = 1'b0;
   logic bootstrap_n = 1'b1;
   int mismatches = 0;
   int num_checks = 0;

   always #20 clk = ~clk;

   bsio_core bsio_core_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .serial_in_line(serial_in_line),
      .serial_out_line(serial_out_line), .output_strobe(output_strobe), .addr_bus(addr_bus),
      .addr_oe(addr_oe), .memory_cycle_enable(memory_cycle_enable), .mem_we(mem_we), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .hold_req(hold_req), .hold_acknowledge(hold_acknowledge),
      .intr_req(intr_req), .bootstrap_n(bootstrap_n));

   bsio_far_model bsio_far_model_inst (.clk(clk), .serial_out_line(serial_out_line),
      .output_strobe(output_strobe), .serial_in_line(serial_in_line), .addr_bus(addr_bus),
      .memory_cycle_enable(memory_cycle_enable), .mem_we(mem_we), .data_out(data_out),
      .data_oe(data_oe), .data_in(data_in));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic print_verdict();
      if (mismatches == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         mismatches++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask : rdchk

   // Polls status until the masked bits drop; a hang ends the run
   task automatic wait_clear(input logic [15:0] m);
      logic [15:0] s;
      for (int i = 0; i < 300; i++) begin
         rd(`BSIO_OFS_STAT, s);
         if ((s & m) === 16'h0000)
            return;
      end
      mismatches++;
      print_verdict();
   endtask : wait_clear

   task automatic run(input logic [3:0] c, input logic [2:0] op, input logic v, input logic [7:0] d);
      wr(`BSIO_OFS_CMD, {c, op, v, d});
      wait_clear(16'h0001);
   endtask : run

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      static logic [7:0] disp [4] = '{8'hff, 8'h7f, 8'h80, 8'h80};
      static logic [2:0] codes [4] = '{3'h7, 3'h6, 3'h5, 3'h3};
      logic [11:0] ba;
      logic [15:0] w;
      int s0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(`BSIO_OFS_STAT, 16'h0000);
      rdchk(`BSIO_OFS_ST, 16'h0000);
      rdchk(8'h20, 16'h0000);
      wr(`BSIO_OFS_BASE, 16'h0200);
      for (int i = 0; i < 4; i++) begin
         ba = 12'h100 + {{4{disp[i][7]}}, disp[i]};
         s0 = bsio_far_model_inst.strobes;
         run(4'h0, 3'h1, i != 3, disp[i]);
         chk({15'h0, bsio_far_model_inst.out_bits[ba]}, {15'h0, i != 3});
         chk(16'(bsio_far_model_inst.strobes - s0), 16'h0001);
      end
      bsio_far_model_inst.in_bits[12'h0fe] = 1'b1;
      run(4'h0, 3'h2, 1'b0, 8'hfe);
      rdchk(`BSIO_OFS_ST, 16'h2000);
      run(4'h0, 3'h2, 1'b0, 8'h03);
      rdchk(`BSIO_OFS_ST, 16'h0000);
      wr(`BSIO_OFS_DATA, 16'ha5c3);
      run(4'h0, 3'h3, 1'b0, 8'h00);
      for (int i = 0; i < 16; i++)
         w[i] = bsio_far_model_inst.out_bits[12'h100 + i];
      chk(w, 16'ha5c3);
      wr(`BSIO_OFS_BASE, 16'h0400);
      wr(`BSIO_OFS_DATA, 16'h3c96);
      run(4'h5, 3'h3, 1'b0, 8'h01);
      w = 16'h0000;
      for (int i = 0; i < 6; i++)
         w[i] = bsio_far_model_inst.out_bits[12'h200 + i];
      chk(w, 16'h0016);
      wr(`BSIO_OFS_BASE, 16'h0600);
      for (int i = 0; i < 16; i++)
         bsio_far_model_inst.in_bits[12'h300 + i] = w[i] ^ (16'h6d2f >> i);
      wr(`BSIO_OFS_DATA, 16'h0000);
      run(4'h0, 3'h4, 1'b0, 8'h00);
      rdchk(`BSIO_OFS_DATA, 16'h6d39);
      wr(`BSIO_OFS_DATA, 16'hffff);
      run(4'h3, 3'h4, 1'b0, 8'h00);
      rdchk(`BSIO_OFS_DATA, 16'h01ff);
      for (int i = 0; i < 4; i++) begin
         s0 = bsio_far_model_inst.strobes;
         run(4'h0, 3'h5, 1'b0, {5'h00, codes[i]});
         chk({13'h0, bsio_far_model_inst.last_code}, {13'h0, codes[i]});
         chk(16'(bsio_far_model_inst.strobes - s0), 16'h0001);
      end
      s0 = bsio_far_model_inst.strobes;
      wr(`BSIO_OFS_CMD, {4'h0, 3'h5, 1'b0, 8'h02});
      repeat (24) @(posedge clk);
      rdchk(`BSIO_OFS_STAT, 16'h0003);
      chk(16'(bsio_far_model_inst.strobes - s0 >= 5), 16'h0001);
      chk({13'h0, bsio_far_model_inst.last_code}, 16'h0002);
      intr_req <= 1'b1;
      wait_clear(16'h0002);
      intr_req <= 1'b0;
      bsio_far_model_inst.mem[15'h7ffe] = 16'h0100;
      bsio_far_model_inst.mem[15'h7fff] = 16'h0200;
      wr(`BSIO_OFS_WP, 16'h1234);
      wr(`BSIO_OFS_PC, 16'h5678);
      wr(`BSIO_OFS_ST, 16'h200f);
      bootstrap_n <= 1'b0;
      repeat (4) @(posedge clk);
      bootstrap_n <= 1'b1;
      wait_clear(16'h0005);
      rdchk(`BSIO_OFS_WP, 16'h0100);
      rdchk(`BSIO_OFS_PC, 16'h0200);
      rdchk(`BSIO_OFS_ST, 16'h2000);
      chk(bsio_far_model_inst.mem[15'h008d], 16'h1234);
      chk(bsio_far_model_inst.mem[15'h008e], 16'h5678);
      chk(bsio_far_model_inst.mem[15'h008f], 16'h200f);
      hold_req <= 1'b1;
      repeat (6) @(posedge clk);
      chk({14'h0, hold_acknowledge, addr_oe}, 16'h0002);
      hold_req <= 1'b0;
      repeat (6) @(posedge clk);
      chk({14'h0, hold_acknowledge, addr_oe}, 16'h0001);
      print_verdict();
   end
endmodule : testbench
